// ==== inc/ecph_params.svh ====
// constants of the ecp host handshake port
`ifndef ECPH_PARAMS_SVH
`define ECPH_PARAMS_SVH
`define ECPH_DATA_W 8
`define ECPH_FIFO_W 9
`define ECPH_FIFO_DEPTH 32
`define ECPH_PTR_W 5
`define ECPH_CNT_W 6
`define ECPH_CMD_BIT 8
`define ECPH_PD_RST 8'h00
`endif

// ==== inc/ecph_pkg.sv ====
// types shared by the ecp host handshake port
`include "ecph_params.svh"
package ecph_pkg;
    // one-hot handshake states
    typedef enum logic [7:0] {
        ST_COMPAT = 8'h01,
        ST_FIDLE = 8'h02,
        ST_FACK = 8'h04,
        ST_FREL = 8'h08,
        ST_RREQ = 8'h10,
        ST_RIDLE = 8'h20,
        ST_RACK = 8'h40,
        ST_RFIN = 8'h80
    } ecph_state_e;

    // peripheral-driven status lines
    typedef struct packed {
        logic ack_n;
        logic pe;
        logic slct;
        logic err_n;
        logic busy;
    } ecph_stat_s;

    // one forward byte with its command mark
    typedef struct packed {
        logic cmd;
        logic [`ECPH_DATA_W-1:0] data;
    } ecph_word_s;
endpackage : ecph_pkg

// ==== verilog/ecph_port.sv ====
// ecp host handshake port with its forward fifo
`timescale 1ns/10ps
`default_nettype none
`include "ecph_params.svh"

module ecph_fifo #(
    parameter int W = `ECPH_FIFO_W,
    parameter int D = `ECPH_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // filling side
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [W-1:0] wr_data,
    // draining side
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [W-1:0] rd_data
);
    localparam int PW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
        logic full;
        logic ne;
    } ecph_fifo_s;
    ecph_fifo_s q_r, q_nxt;
    logic do_wr, do_rd;

    // flags are registered alongside the count so ready/valid come from flops
    always_comb begin
        q_nxt = q_r;
        do_wr = wr_valid && !q_r.full;
        do_rd = rd_ready && q_r.ne;
        if (do_wr) begin
            q_nxt.mem[q_r.wp] = wr_data;
            q_nxt.wp = PW'(q_r.wp + 1'b1);
        end
        if (do_rd) begin
            q_nxt.rp = PW'(q_r.rp + 1'b1);
        end
        q_nxt.cnt = (PW+1)'(q_r.cnt + {{PW{1'b0}}, do_wr} - {{PW{1'b0}}, do_rd});
        q_nxt.full = (q_nxt.cnt == (PW+1)'(D));
        q_nxt.ne = (q_nxt.cnt != '0);
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign wr_ready = !q_r.full;
    assign rd_valid = q_r.ne;
    assign rd_data = q_r.mem[q_r.rp];

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    fifo_bound_a: assert property (q_r.cnt <= (PW+1)'(D))
        else $error("fifo count beyond depth");
endmodule : ecph_fifo

// How it works
// - eight-bit data bus carries data and address bytes forward, and only unmarked data bytes in reverse
// - host drives slin and interlocks it with busy for each forward byte
// - strobe stays high for as long as the link is in ecp mode
// - host drives strobe low to return the link to compatibility mode
// - reverse flow control uses active-low autofeed interlocked with acknowledge
// - forward autofeed level marks the current byte as command or data
// - init low reverses the channel; only then may peripheral drive bus
// - error low requests host service, honoured only in forward direction
module ecph_port
    import ecph_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // user control levels
    input wire logic ecp_en,
    input wire logic rev_req,
    // forward byte stream
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [`ECPH_DATA_W-1:0] tx_data,
    input wire logic tx_cmd,
    // reverse byte stream
    output logic rx_valid,
    output logic [`ECPH_DATA_W-1:0] rx_data,
    // link status to user
    output logic rev_active,
    output logic periph_req,
    output logic periph_sel,
    // parallel data bus
    input wire logic [`ECPH_DATA_W-1:0] pd_in,
    output logic [`ECPH_DATA_W-1:0] pd_out,
    output logic pd_oe,
    // host-driven control lines
    output logic slin,
    output logic stb,
    output logic afd_n,
    output logic init_n,
    // peripheral-driven status lines
    input wire logic ack_n,
    input wire logic pe,
    input wire logic slct,
    input wire logic err_n,
    input wire logic busy
);
    typedef struct packed {
        ecph_state_e st;
        ecph_stat_s meta;
        ecph_stat_s sync;
        logic [`ECPH_DATA_W-1:0] pd_out;
        logic pd_oe;
        logic slin;
        logic stb;
        logic afd_n;
        logic init_n;
        logic rx_valid;
        logic [`ECPH_DATA_W-1:0] rx_data;
        logic rev_active;
        logic periph_req;
        logic periph_sel;
        logic tx_ready;
    } ecph_port_s;
    ecph_port_s q_r, q_nxt;
    ecph_stat_s pins;
    ecph_word_s tx_word, fifo_word;
    logic fifo_valid, fifo_pop, fifo_push, fifo_wr_ready;
    assign pins = '{ack_n: ack_n, pe: pe, slct: slct, err_n: err_n, busy: busy};
    assign tx_word = '{cmd: tx_cmd, data: tx_data};
    assign fifo_push = tx_valid && tx_ready; // no byte enters without tx_ready shown high
    // popping only in forward idle lets the fifo fill while the peripheral stalls
    assign fifo_pop = (q_r.st == ST_FIDLE) && ecp_en && !rev_req && !q_r.sync.busy;
    ecph_fifo #(.W(`ECPH_FIFO_W), .D(`ECPH_FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .srst(srst),
        .wr_valid(fifo_push),
        .wr_ready(fifo_wr_ready),
        .wr_data(tx_word),
        .rd_valid(fifo_valid),
        .rd_ready(fifo_pop),
        .rd_data(fifo_word)
    );
    // handshake sequencing; outputs other than tx_ready are struct fields so they come from flops
    always_comb begin
        q_nxt = q_r;
        q_nxt.meta = pins;
        q_nxt.sync = q_r.meta;
        q_nxt.rx_valid = 1'b0;
        case (q_r.st)
            ST_COMPAT: begin
                q_nxt.stb = 1'b0;
                if (ecp_en) begin
                    q_nxt.st = ST_FIDLE;
                    q_nxt.stb = 1'b1;
                    q_nxt.pd_oe = 1'b1;
                end
            end
            ST_FIDLE: begin
                if (!ecp_en) begin
                    q_nxt.st = ST_COMPAT;
                    q_nxt.stb = 1'b0;
                end else if (rev_req) begin
                    q_nxt.st = ST_RREQ;
                    q_nxt.pd_oe = 1'b0;
                    q_nxt.init_n = 1'b0;
                end else if (fifo_pop && fifo_valid) begin
                    q_nxt.st = ST_FACK;
                    q_nxt.pd_out = fifo_word.data;
                    q_nxt.afd_n = !fifo_word.cmd;
                    q_nxt.slin = 1'b0;
                end
            end
            ST_FACK: begin
                // peripheral raises busy once it has taken the byte
                if (q_r.sync.busy) begin
                    q_nxt.st = ST_FREL;
                    q_nxt.slin = 1'b1;
                end
            end
            ST_FREL: begin
                if (!q_r.sync.busy) begin
                    q_nxt.st = ST_FIDLE;
                    q_nxt.afd_n = 1'b1;
                end
            end
            ST_RREQ: begin
                // bus already released; wait for the grant on pe
                if (!q_r.sync.pe) begin
                    q_nxt.st = ST_RIDLE;
                    q_nxt.afd_n = 1'b0;
                end
            end
            ST_RIDLE: begin
                if (!rev_req) begin
                    q_nxt.st = ST_RFIN;
                    q_nxt.afd_n = 1'b1;
                    q_nxt.init_n = 1'b1;
                end else if (!q_r.sync.ack_n) begin
                    q_nxt.st = ST_RACK;
                    q_nxt.rx_data = pd_in;
                    q_nxt.rx_valid = 1'b1;
                    q_nxt.afd_n = 1'b1;
                end
            end
            ST_RACK: begin
                if (q_r.sync.ack_n) begin
                    q_nxt.st = ST_RIDLE;
                    q_nxt.afd_n = 1'b0;
                end
            end
            ST_RFIN: begin
                // take the bus back only after the peripheral drops its grant
                if (q_r.sync.pe) begin
                    q_nxt.st = ST_FIDLE;
                    q_nxt.pd_oe = 1'b1;
                end
            end
            default: begin
                q_nxt.st = ST_COMPAT;
            end
        endcase
        q_nxt.rev_active = (q_nxt.st == ST_RIDLE) || (q_nxt.st == ST_RACK);
        // error request counts only while the channel runs forward
        q_nxt.periph_req = !q_r.sync.err_n && q_r.init_n && (q_r.st != ST_COMPAT);
        q_nxt.periph_sel = q_r.sync.slct;
        q_nxt.tx_ready = fifo_wr_ready; // one cycle late; the and below refuses at once when full
    end
    // state register
    always_ff @(posedge clk) begin
        if (srst) begin
            q_r <= '0;
            q_r.st <= ST_COMPAT;
            q_r.meta <= '{ack_n: 1'b1, pe: 1'b1, slct: 1'b0, err_n: 1'b1, busy: 1'b0};
            q_r.sync <= '{ack_n: 1'b1, pe: 1'b1, slct: 1'b0, err_n: 1'b1, busy: 1'b0};
            q_r.pd_out <= `ECPH_PD_RST;
            q_r.slin <= 1'b1;
            q_r.afd_n <= 1'b1;
            q_r.init_n <= 1'b1;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign tx_ready = q_r.tx_ready && fifo_wr_ready;
    assign rx_valid = q_r.rx_valid;
    assign rx_data = q_r.rx_data;
    assign rev_active = q_r.rev_active;
    assign periph_req = q_r.periph_req;
    assign periph_sel = q_r.periph_sel;
    assign pd_out = q_r.pd_out;
    assign pd_oe = q_r.pd_oe;
    assign slin = q_r.slin;
    assign stb = q_r.stb;
    assign afd_n = q_r.afd_n;
    assign init_n = q_r.init_n;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence fwd_start_s;
        (q_r.st == ST_FIDLE) && ecp_en && !rev_req && fifo_pop && fifo_valid;
    endsequence
    sequence rev_byte_s;
        (q_r.st == ST_RIDLE) && rev_req && !q_r.sync.ack_n;
    endsequence
    stb_hold_a: assert property ((q_r.st != ST_COMPAT) |-> stb)
        else $error("strobe low inside ecp mode");
    stb_exit_a: assert property ((q_r.st == ST_FIDLE && !ecp_en) |=> !stb && q_r.st == ST_COMPAT)
        else $error("strobe not dropped on ecp exit");
    fwd_start_a: assert property (fwd_start_s |=> !slin && pd_oe && pd_out == $past(fifo_word.data))
        else $error("forward byte not launched");
    cmd_mark_a: assert property (fwd_start_s |=> afd_n == !$past(fifo_word.cmd))
        else $error("command mark wrong");
    slin_release_a: assert property ((q_r.st == ST_FACK && q_r.sync.busy) |=> slin ##0 $stable(pd_out))
        else $error("slin not released after busy");
    bus_release_a: assert property (!init_n |-> !pd_oe)
        else $error("host drives bus while reversed");
    rev_capture_a: assert property (rev_byte_s |=> rx_valid && afd_n && rx_data == $past(pd_in))
        else $error("reverse byte not captured");
    rev_ready_a: assert property ((q_r.st == ST_RACK && q_r.sync.ack_n) |=> !afd_n ##1 !rx_valid)
        else $error("autofeed not re-armed");
    err_fwd_a: assert property (!init_n |=> !periph_req)
        else $error("error request seen in reverse");
    sync_delay_a: assert property (q_r.sync.ack_n == $past(ack_n, 2))
        else $error("ack synchroniser depth wrong");
endmodule : ecph_port
`default_nettype wire

// ==== tb/ecph_periph_model.sv ====
// behavioural ecp peripheral facing the host port
`timescale 1ns/10ps
`default_nettype none

module ecph_periph_model (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // host lines and pacing
    input wire logic slin,
    input wire logic init_n,
    input wire logic afd_n,
    input wire logic slow,
    // peripheral lines
    output logic busy,
    output logic pe,
    output logic ack_n,
    output logic [7:0] pd_q,
    output logic pd_en
);
    logic [3:0] dly;
    logic [7:0] nxt_byte;

    // slow mode answers four cycles late to stress the interlock
    always_ff @(posedge clk) begin
        if (srst) begin
            busy <= 1'b0;
            pe <= 1'b1;
            ack_n <= 1'b1;
            pd_en <= 1'b0;
            pd_q <= 8'h00;
            dly <= 4'h0;
            nxt_byte <= 8'hA5;
        end else begin
            dly <= {dly[2:0], !slin};
            busy <= slow ? dly[3] : !slin;
            pe <= init_n;
            pd_en <= !init_n;
            if (!init_n && !afd_n && ack_n) begin
                pd_q <= nxt_byte;
                ack_n <= 1'b0;
            end else if (afd_n && !ack_n) begin
                ack_n <= 1'b1;
                nxt_byte <= nxt_byte + 8'h01;
            end
        end
    end
endmodule : ecph_periph_model
`default_nettype wire

// ==== tb/ecph_port_tb_top.sv ====
// self-checking bench for the ecp host handshake port
`timescale 1ns/10ps
`default_nettype none
`include "ecph_params.svh"

module ecph_port_tb_top;
    import ecph_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ecp_en = 1'b0;
    logic rev_req = 1'b0;
    logic tx_valid = 1'b0;
    logic tx_cmd = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic err_n = 1'b1;
    logic slct = 1'b0;
    logic slow = 1'b1;
    logic ecp_on = 1'b0;
    logic tx_ready, rx_valid, rev_active, periph_req, periph_sel, pd_oe;
    logic slin, stb, afd_n, init_n, ack_n, pe, busy, pd_en, slin_q;
    logic [7:0] rx_data, pd_out, pd_q, pd_in;
    logic [8:0] fwd_q[$];
    logic [7:0] rev_q[$];
    int failures = 0;
    int comparisons = 0;
    int i;

    always #50 clk = ~clk;

    // released bus shows the inverse of the last value, never a held copy
    assign pd_in = pd_oe ? pd_out : (pd_en ? pd_q : ~pd_q);

    ecph_port uut (.clk(clk), .srst(srst), .ecp_en(ecp_en), .rev_req(rev_req),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_cmd(tx_cmd),
        .rx_valid(rx_valid), .rx_data(rx_data), .rev_active(rev_active),
        .periph_req(periph_req), .periph_sel(periph_sel), .pd_in(pd_in), .pd_out(pd_out),
        .pd_oe(pd_oe), .slin(slin), .stb(stb), .afd_n(afd_n), .init_n(init_n),
        .ack_n(ack_n), .pe(pe), .slct(slct), .err_n(err_n), .busy(busy));

    ecph_periph_model periph (.clk(clk), .srst(srst), .slin(slin), .init_n(init_n),
        .afd_n(afd_n), .slow(slow), .busy(busy), .pe(pe), .ack_n(ack_n), .pd_q(pd_q),
        .pd_en(pd_en));

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic stop_test;
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    task automatic expire(input logic ok);
        if (ok !== 1'b1) begin
            failures++;
            stop_test();
        end
    endtask : expire

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask : tick

    // capture link and returned bytes at the falling edge, where outputs have settled
    always @(negedge clk) begin
        slin_q <= slin;
        if (slin_q === 1'b1 && slin === 1'b0) fwd_q.push_back({!afd_n, pd_out});
        if (rx_valid === 1'b1) rev_q.push_back(rx_data);
        if (srst === 1'b0) chk({8'h00, pd_oe & pd_en}, 9'h000);
        if (ecp_on) chk({8'h00, stb}, 9'h001);
    end

    task automatic t_reset;
        chk({4'h0, stb, slin, afd_n, init_n, pd_oe}, 9'h00E);
    endtask : t_reset

    // link stays in compatibility mode, so the fifo only fills
    task automatic t_fill;
        int n;
        n = 0;
        tx_valid = 1'b1;
        for (i = 0; i < 40; i++) begin
            tx_data = 8'h40 + 8'(n);
            tx_cmd = n[0];
            // ready has settled here and is what the port samples at the next edge
            if (tx_ready === 1'b1) n++;
            @(posedge clk);
            #10;
        end
        tx_valid = 1'b0;
        chk(9'(n), 9'h020);
        chk({8'h00, tx_ready}, 9'h000);
    endtask : t_fill

    task automatic t_drain;
        ecp_en = 1'b1;
        for (i = 0; i < 20 && stb !== 1'b1; i++) tick(1);
        expire(stb === 1'b1);
        ecp_on = 1'b1;
        chk({8'h00, pd_oe}, 9'h001);
        for (i = 0; i < 3000 && fwd_q.size() < 32; i++) begin
            tick(1);
            if (fwd_q.size() == 16) slow = 1'b0;
        end
        expire(fwd_q.size() == 32);
        for (i = 0; i < 32; i++) chk(fwd_q.pop_front(), {i[0], 8'h40 + 8'(i)});
        for (i = 0; i < 50 && afd_n !== 1'b1; i++) tick(1);
        expire(afd_n === 1'b1);
    endtask : t_drain

    // synchronised status needs two flops plus the output register
    task automatic t_status;
        slct = 1'b1;
        err_n = 1'b0;
        tick(1);
        chk({7'h00, periph_sel, periph_req}, 9'h000);
        tick(3);
        chk({7'h00, periph_sel, periph_req}, 9'h003);
    endtask : t_status

    task automatic t_reverse;
        rev_req = 1'b1;
        for (i = 0; i < 20 && init_n !== 1'b0; i++) tick(1);
        expire(init_n === 1'b0);
        chk({8'h00, pd_oe}, 9'h000);
        for (i = 0; i < 300 && rev_q.size() < 2; i++) tick(1);
        expire(rev_q.size() >= 2);
        chk({1'b0, rev_q.pop_front()}, 9'h0A5);
        chk({1'b0, rev_q.pop_front()}, 9'h0A6);
        chk({7'h00, periph_req, rev_active}, 9'h001);
        rev_req = 1'b0;
        for (i = 0; i < 100 && pd_oe !== 1'b1; i++) tick(1);
        expire(pd_oe === 1'b1);
        chk({8'h00, init_n}, 9'h001);
        tick(4);
        chk({8'h00, periph_req}, 9'h001);
    endtask : t_reverse

    task automatic t_exit;
        err_n = 1'b1;
        ecp_on = 1'b0;
        ecp_en = 1'b0;
        for (i = 0; i < 20 && stb !== 1'b0; i++) tick(1);
        expire(stb === 1'b0);
        chk({8'h00, stb}, 9'h000);
    endtask : t_exit

    initial begin
        tick(8);
        srst = 1'b0;
        tick(2);
        t_reset();
        t_fill();
        t_drain();
        t_status();
        t_reverse();
        t_exit();
        stop_test();
    end
endmodule : ecph_port_tb_top
`default_nettype wire
